// ### dv/e1rs_line_model.sv
`timescale 1ns/10ps
`default_nettype none

// Line receiver stand-in: one received bit every other clock
module e1rs_line_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] mode_i,
    output logic            bit_strobe_o,
    output logic            line_bit_o
);
    logic [2:0] phase;

    // Mode 0 all ones, 1 silence, 2 one pulse in eight (12.5 percent)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase        <= 3'h0;
            bit_strobe_o <= 1'b0;
            line_bit_o   <= 1'b1;
        end else begin
            bit_strobe_o <= ~bit_strobe_o;
            if (!bit_strobe_o) begin
                phase      <= phase + 3'h1;
                line_bit_o <= (mode_i == 2'h0) || (mode_i == 2'h2 && phase == 3'h0);
            end
        end
    end
endmodule // e1rs_line_model

`default_nettype wire

// ### dv/tb_e1_receive_status_words.sv
`timescale 1ns/10ps
`default_nettype none

module tb_e1_receive_status_words;
    import e1rs_pkg::*;

    logic           clk_i = 1'b0;
    logic           rst_i = 1'b1;
    e1rs_wb_req_t   req = '0;
    logic           wb_ack_o;
    logic [31:0]    wb_dat_o;
    logic           tick = 1'b0;
    logic           bp_pulse = 1'b0;
    logic           rx_pulse = 1'b0;
    logic           slowed = 1'b0;
    logic           sped = 1'b0;
    logic [5:0]     fifo_lvl = 6'h00;
    logic [5:0]     atten = 6'h00;
    logic [1:0]     mode = 2'h0;
    logic           bit_stb;
    logic           bit_val;
    logic           ais_b = 1'b0;
    logic           sec = 1'b0;
    logic           ebit = 1'b0;
    logic           ais_a = 1'b1;
    logic           sync_lost = 1'b0;
    e1rs_frame_ev_t ev = '0;
    logic [7:0]     rd;
    int             fail_count = 0;
    int             comparisons = 0;
    int             cycles = 0;

    // Clock and hang guard
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            summarize();
        end
    end

    e1rs_status_regs #(.FIFO_DEPTH(32), .LINE_AMPLITUDE_LOST_CYC(20)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .eighth_tick_i(tick), .backplane_frame_pulse_i(bp_pulse), .receive_frame_pulse_i(rx_pulse),
        .dejitter_clock_slowed_i(slowed), .dejitter_clock_sped_i(sped),
        .jitter_fifo_level_i(fifo_lvl), .line_atten_db_i(atten), .bit_strobe_i(bit_stb),
        .line_bit_i(bit_val), .ais_criterion_a_i(ais_a), .ais_criterion_b_i(ais_b),
        .second_tick_i(sec), .ebit_error_i(ebit), .frame_sync_lost_i(sync_lost), .frame_ev_i(ev));

    e1rs_line_model i_line (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode),
        .bit_strobe_o(bit_stb), .line_bit_o(bit_val));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] wd);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {idx, 2'b00}, dat: {24'h0, wd}};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        req <= '0;
        @(posedge clk_i);
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk8(rd & mask, exp);
    endtask

    // One-cycle frame event; packed order as declared
    task automatic pulse(input logic [15:0] e);
        ev <= e1rs_frame_ev_t'(e);
        @(posedge clk_i);
        ev <= '0;
        @(posedge clk_i);
    endtask

    task automatic t_ident();
        rdc(IDX_IDENT, 8'hff, IDENT_VALUE);
        wb(1'b1, IDX_IDENT, 8'ha5);
        rdc(IDX_IDENT, 8'hff, IDENT_VALUE);
        rdc(6'h03, 8'hff, 8'h00);
        $display("test ident done");
    endtask

    task automatic t_jitter();
        logic [5:0] lv [8] = '{6'h00, 6'h03, 6'h04, 6'h0f, 6'h10, 6'h1b, 6'h1c, 6'h20};
        logic [7:0] ex [8] = '{8'h20, 8'h00, 8'h10, 8'h10, 8'h18, 8'h18, 8'h1c, 8'h1e};
        for (int i = 0; i < 8; i++) begin
            fifo_lvl <= lv[i];
            @(posedge clk_i);
            rdc(IDX_JITTER, 8'hfe, ex[i]);
        end
        slowed <= 1'b1;
        @(posedge clk_i);
        rdc(IDX_JITTER, 8'hc0, 8'h80);
        slowed <= 1'b0;
        sped <= 1'b1;
        @(posedge clk_i);
        rdc(IDX_JITTER, 8'hc0, 8'h40);
        sped <= 1'b0;
        $display("test jitter done");
    endtask

    task automatic t_signal();
        logic [5:0] av [5] = '{6'h05, 6'h06, 6'h0b, 6'h0c, 6'h14};
        logic [7:0] ex [5] = '{8'h20, 8'h40, 8'h40, 8'h80, 8'h80};
        for (int i = 0; i < 5; i++) begin
            atten <= av[i];
            repeat (30) @(posedge clk_i);
            rdc(IDX_SIGNAL, 8'hff, ex[i]);
        end
        atten <= 6'h15;
        repeat (10) @(posedge clk_i);
        rdc(IDX_SIGNAL, 8'hff, 8'h80);
        repeat (20) @(posedge clk_i);
        rdc(IDX_SIGNAL, 8'hff, 8'h90);
        atten <= 6'h00;
        repeat (2) @(posedge clk_i);
        rdc(IDX_SIGNAL, 8'hff, 8'h20);
        $display("test signal done");
    endtask

    // Backplane pulse, 300 eighth-bit ticks, then receive pulse
    task automatic t_phase();
        bp_pulse <= 1'b1;
        @(posedge clk_i);
        bp_pulse <= 1'b0;
        tick <= 1'b1;
        repeat (300) @(posedge clk_i);
        tick <= 1'b0;
        rx_pulse <= 1'b1;
        @(posedge clk_i);
        rx_pulse <= 1'b0;
        rdc(IDX_PHASE_LOW, 8'hff, 8'h2c);
        rdc(IDX_PHASE_HIGH, 8'h0f, 8'h01);
        $display("test phase done");
    endtask

    task automatic t_los();
        mode <= 2'h1;
        repeat (300) @(posedge clk_i);
        rdc(IDX_ALARM, 8'h10, 8'h10);
        mode <= 2'h2;
        repeat (400) @(posedge clk_i);
        rdc(IDX_ALARM, 8'h10, 8'h00);
        mode <= 2'h0;
        $display("test los done");
    endtask

    task automatic t_alarms();
        pulse(16'hffc0);
        rdc(IDX_ALARM, 8'hcf, 8'hcf);
        ais_a <= 1'b0;
        @(posedge clk_i);
        rdc(IDX_ALARM, 8'h04, 8'h00);
        ais_a <= 1'b1;
        wb(1'b1, IDX_CONTROL, 8'h01);
        pulse(16'haa80);
        rdc(IDX_ALARM, 8'hcf, 8'h00);
        ais_b <= 1'b1;
        @(posedge clk_i);
        rdc(IDX_ALARM, 8'h04, 8'h04);
        $display("test alarms done");
    endtask

    // Opening tick starts a clean second; sync loss spoils the sixth second
    task automatic t_remote();
        sec <= 1'b1;
        @(posedge clk_i);
        sec <= 1'b0;
        for (int s = 0; s < 6; s++) begin
            sync_lost <= (s == 5);
            repeat (990) begin
                ebit <= 1'b1;
                @(posedge clk_i);
                ebit <= 1'b0;
                @(posedge clk_i);
            end
            sec <= 1'b1;
            @(posedge clk_i);
            sec <= 1'b0;
            rdc(IDX_ALARM, 8'h20, (s == 4) ? 8'h20 : 8'h00);
        end
        sync_lost <= 1'b0;
        $display("test remote done");
    endtask

    task automatic t_spare();
        repeat (8) pulse(16'h0033);
        rdc(IDX_SPARE, 8'hff, 8'hca);
        rdc(IDX_SPARE, 8'hff, 8'h00);
        pulse(16'h0026);
        rdc(IDX_SPARE, 8'h01, 8'h01);
        rdc(IDX_SPARE, 8'h01, 8'h00);
        fork
            rdc(IDX_SPARE, 8'h01, 8'h00);
            pulse(16'h0032);
        join
        rdc(IDX_SPARE, 8'h01, 8'h01);
        $display("test spare done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_ident();
        t_jitter();
        t_signal();
        t_phase();
        t_los();
        t_alarms();
        t_remote();
        t_spare();
        summarize();
    end
endmodule // tb_e1_receive_status_words

`default_nettype wire

// ### hw/e1rs_pkg.sv
package e1rs_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_PHASE_HIGH  = 6'h15;
    localparam logic [5:0] IDX_PHASE_LOW   = 6'h16;
    localparam logic [5:0] IDX_JITTER      = 6'h17;
    localparam logic [5:0] IDX_SIGNAL      = 6'h18;
    localparam logic [5:0] IDX_ALARM       = 6'h19;
    localparam logic [5:0] IDX_SPARE       = 6'h1a;
    localparam logic [5:0] IDX_IDENT       = 6'h1f;
    localparam logic [5:0] IDX_CONTROL     = 6'h10;

    // Field positions of the control word
    localparam int CTRL_AIS_SEL_BIT = 0;

    // Reset value and fixed identification value
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [7:0] IDENT_VALUE = 8'h5c;  // Arbitrary identification value

    // Phase counter width in eighth-bit steps
    localparam int PHASE_W = 12;

    // Loss-of-signal thresholds
    localparam logic [6:0] LOS_ZERO_RUN   = 7'h7f;  // 127 zero bit periods
    localparam logic [6:0] LOS_WINDOW     = 7'h7f;  // 127 pulse positions
    localparam logic [6:0] LOS_MIN_ONES   = 7'h10;  // 12.5 percent of 127, rounded up

    // Line amplitude classes, attenuation in dB
    localparam logic [5:0] ATTEN_LOST_DB   = 6'h14;  // 20 dB
    localparam logic [5:0] ATTEN_HEAVY_DB  = 6'h0c;
    localparam logic [5:0] ATTEN_MEDIUM_DB = 6'h06;

    // Amplitude loss qualification time
    localparam int CLK_MHZ       = 125;
    localparam int LINE_AMPLITUDE_LOST_TIME_US  = 1000;
    localparam int LINE_AMPLITUDE_LOST_CYCLES   = LINE_AMPLITUDE_LOST_TIME_US * CLK_MHZ;

    // Remote failure figures
    localparam logic [9:0] EBIT_LIMIT   = 10'h3dd;  // 989 errors per second
    localparam logic [2:0] REMOTE_MULTIFRAME_FAILURE_SECS   = 3'h5;

    // Spare bit repetition count
    localparam logic [2:0] SA6_REPEAT   = 3'h7;  // Eighth equal nibble

    // Classic Wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } e1rs_wb_req_t;

    // Per-frame receive events from the framer
    typedef struct packed {
        logic       frame_strobe;     // One pulse per frame
        logic       ts16_all_ones;    // Timeslot 16 held all ones this frame
        logic       nfas_strobe;      // Non-frame-alignment frame pulse
        logic       remote_a_bit;     // A bit of that frame
        logic       multiframe_strobe;
        logic       rai_crc_run;      // Remote alarm with continuous CRC errors
        logic       smf1_done;
        logic       smf1_error;
        logic       smf2_done;
        logic       smf2_error;
        logic       sa6_valid;        // Sa6 nibble complete
        logic [3:0] sa6_nibble;
        logic       sa5_bit;
    } e1rs_frame_ev_t;

endpackage

// ### hw/e1rs_status_regs.sv
`timescale 1ns/10ps
`default_nettype none

module e1rs_status_regs
    import e1rs_pkg::*;
#(
    parameter int FIFO_DEPTH  = 32,
    parameter int LINE_AMPLITUDE_LOST_CYC    = LINE_AMPLITUDE_LOST_CYCLES
) (
    input  wire logic                              clk_i,
    input  wire logic                              rst_i,
    input  wire e1rs_wb_req_t                      wb_req_i,
    output logic                                   wb_ack_o,
    output logic [31:0]                            wb_dat_o,
    input  wire logic                              eighth_tick_i,
    input  wire logic                              backplane_frame_pulse_i,
    input  wire logic                              receive_frame_pulse_i,
    input  wire logic                              dejitter_clock_slowed_i,
    input  wire logic                              dejitter_clock_sped_i,
    input  wire logic [$clog2(FIFO_DEPTH+1)-1:0]   jitter_fifo_level_i,
    input  wire logic [5:0]                        line_atten_db_i,
    input  wire logic                              bit_strobe_i,
    input  wire logic                              line_bit_i,
    input  wire logic                              ais_criterion_a_i,
    input  wire logic                              ais_criterion_b_i,
    input  wire logic                              second_tick_i,
    input  wire logic                              ebit_error_i,
    input  wire logic                              frame_sync_lost_i,
    input  wire e1rs_frame_ev_t                    frame_ev_i
);

    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam int TW = $clog2(LINE_AMPLITUDE_LOST_CYC + 1);
    localparam logic [LW-1:0] LVL_FULL = LW'(FIFO_DEPTH);
    localparam logic [LW-1:0] LVL_HALF = LW'(FIFO_DEPTH / 2);
    localparam logic [LW-1:0] LVL_FOUR = LW'(4);
    localparam logic [LW-1:0] LVL_NEAR = LW'(FIFO_DEPTH - 4);
    localparam logic [TW-1:0] LINE_AMPLITUDE_LOST_LAST = TW'(LINE_AMPLITUDE_LOST_CYC - 1);

    // Elaboration checks; the four-word flags need room above and below them
    if (FIFO_DEPTH < 8) $error("FIFO_DEPTH must be at least 8");
    if (LINE_AMPLITUDE_LOST_CYC < 1) $error("LINE_AMPLITUDE_LOST_CYC must be at least 1");

    typedef enum logic [1:0] {
        LOS_IDLE  = 2'b00,
        LOS_LOST  = 2'b01,
        LOS_WIN   = 2'b10
    } e1rs_los_t;

    // Bus decode
    logic        bus_req;
    logic [5:0]  bus_idx;
    logic        wr_take;
    logic [7:0]  rd_byte;
    logic        spare_clear;

    assign bus_req     = wb_req_i.cyc && wb_req_i.stb;
    assign bus_idx     = wb_req_i.adr[7:2];
    assign wr_take     = bus_req && wb_req_i.we && wb_ack_o;
    // Clear where read data is captured, so no event slips in between the two
    assign spare_clear = bus_req && !wb_req_i.we && !wb_ack_o && (bus_idx == IDX_SPARE);

    // State
    logic [PHASE_W-1:0] phase_run;
    logic [PHASE_W-1:0] phase_count;
    logic [7:0]         jitter_word;
    logic [7:0]         signal_word;
    logic               ais_sel;
    logic [TW-1:0]      line_amplitude_lost_timer;
    logic               line_lost;
    logic               crc1_err;
    logic               crc2_err;
    logic               ts16_ones;
    logic               ais_seen;
    logic               rai_seen;
    logic               rai_crc;
    e1rs_los_t          los_state;
    logic [6:0]         zero_run;
    logic [6:0]         win_count;
    logic [6:0]         win_ones;
    logic [9:0]         ebit_count;
    logic               sec_spoiled;
    logic [2:0]         bad_secs;
    logic               remote_multiframe_failure;
    logic [3:0]         last_nibble;
    logic               nibble_seen;
    logic [2:0]         same_run;
    logic [7:0]         spare_word;

    // One-cycle ack, so a master holding cyc and stb sees ack one edge later
    always_ff @(posedge clk_i) begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req && !wb_ack_o;
    end

    // Read multiplexer; unmapped indices read as zero
    always_comb begin
        if (bus_idx == IDX_PHASE_HIGH)
            rd_byte = {4'h0, phase_count[PHASE_W-1:8]};
        else if (bus_idx == IDX_PHASE_LOW)
            rd_byte = phase_count[7:0];
        else if (bus_idx == IDX_JITTER)
            rd_byte = jitter_word;
        else if (bus_idx == IDX_SIGNAL)
            rd_byte = signal_word;
        else if (bus_idx == IDX_ALARM)
            rd_byte = {crc1_err, crc2_err, remote_multiframe_failure, los_state != LOS_IDLE,
                       ts16_ones, ais_seen, rai_seen, rai_crc};
        else if (bus_idx == IDX_SPARE)
            rd_byte = spare_word;
        else if (bus_idx == IDX_IDENT)
            rd_byte = IDENT_VALUE;
        else if (bus_idx == IDX_CONTROL)
            rd_byte = {7'h00, ais_sel};
        else
            rd_byte = RST_BYTE;
    end

    // Read data registered in the cycle before ack
    always_ff @(posedge clk_i) begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_req && !wb_req_i.we && !wb_ack_o)
            wb_dat_o <= {24'h00_0000, rd_byte};
    end

    // Control word; only byte lane 0 carries it
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ais_sel <= 1'b0;
        else if (wr_take && bus_idx == IDX_CONTROL && wb_req_i.sel[0])
            ais_sel <= wb_req_i.dat[CTRL_AIS_SEL_BIT];
    end

    // Phase counter restarts at each backplane pulse, captured at receive pulse; a same-cycle backplane pulse blocks the capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_run   <= '0;
            phase_count <= '0;
        end else if (backplane_frame_pulse_i) begin
            phase_run <= '0;
        end else begin
            if (eighth_tick_i)
                phase_run <= phase_run + 1'b1;
            if (receive_frame_pulse_i)
                phase_count <= phase_run;
        end
    end

    // Jitter FIFO flags sampled once per clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jitter_word <= RST_BYTE;
        end else begin
            jitter_word[7] <= dejitter_clock_slowed_i;
            jitter_word[6] <= dejitter_clock_sped_i;
            jitter_word[5] <= jitter_fifo_level_i == '0;
            jitter_word[4] <= jitter_fifo_level_i >= LVL_FOUR;
            jitter_word[3] <= jitter_fifo_level_i >= LVL_HALF;
            jitter_word[2] <= jitter_fifo_level_i >= LVL_NEAR;
            jitter_word[1] <= jitter_fifo_level_i >= LVL_FULL;
            jitter_word[0] <= 1'b0;
        end
    end

    // Amplitude loss must persist the whole qualification time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_amplitude_lost_timer <= '0;
            line_lost  <= 1'b0;
        end else if (line_atten_db_i <= ATTEN_LOST_DB) begin
            line_amplitude_lost_timer <= '0;
            line_lost  <= 1'b0;
        end else if (line_amplitude_lost_timer == LINE_AMPLITUDE_LOST_LAST) begin
            line_lost <= 1'b1;
        end else begin
            line_amplitude_lost_timer <= line_amplitude_lost_timer + 1'b1;
        end
    end

    // Loop class is mutually exclusive
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            signal_word <= RST_BYTE;
        end else begin
            signal_word[7]   <= line_atten_db_i >= ATTEN_HEAVY_DB;
            signal_word[6]   <= line_atten_db_i >= ATTEN_MEDIUM_DB
                                && line_atten_db_i < ATTEN_HEAVY_DB;
            signal_word[5]   <= line_atten_db_i < ATTEN_MEDIUM_DB;
            signal_word[4]   <= line_lost;
            signal_word[3:0] <= 4'h0;
        end
    end

    // Framed alarms, each refreshed on its own strobe, except ais_seen, which follows the selected criterion every clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc1_err  <= 1'b0;
            crc2_err  <= 1'b0;
            ts16_ones <= 1'b0;
            ais_seen  <= 1'b0;
            rai_seen  <= 1'b0;
            rai_crc   <= 1'b0;
        end else begin
            if (frame_ev_i.smf1_done)
                crc1_err <= frame_ev_i.smf1_error;
            if (frame_ev_i.smf2_done)
                crc2_err <= frame_ev_i.smf2_error;
            if (frame_ev_i.frame_strobe)
                ts16_ones <= frame_ev_i.ts16_all_ones;
            ais_seen <= ais_sel ? ais_criterion_b_i : ais_criterion_a_i;
            if (frame_ev_i.nfas_strobe)
                rai_seen <= frame_ev_i.remote_a_bit;
            if (frame_ev_i.multiframe_strobe)
                rai_crc <= frame_ev_i.rai_crc_run;
        end
    end

    // Loss of signal: zero run to enter, ones density window to leave
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            los_state <= LOS_IDLE;
            zero_run  <= '0;
            win_count <= '0;
            win_ones  <= '0;
        end else if (bit_strobe_i) begin
            case (los_state)
                LOS_IDLE: begin
                    if (line_bit_i) begin
                        zero_run <= '0;
                    end else if (zero_run == LOS_ZERO_RUN - 7'h01) begin
                        zero_run  <= '0;
                        los_state <= LOS_LOST;
                    end else begin
                        zero_run <= zero_run + 7'h01;
                    end
                end
                LOS_LOST: begin
                    // Window opens only on a pulse
                    if (line_bit_i) begin
                        win_count <= 7'h01;
                        win_ones  <= 7'h01;
                        los_state <= LOS_WIN;
                    end
                end
                LOS_WIN: begin
                    if (win_count == LOS_WINDOW - 7'h01) begin
                        if (win_ones + {6'h00, line_bit_i} >= LOS_MIN_ONES)
                            los_state <= LOS_IDLE;
                        else
                            los_state <= LOS_LOST;
                        win_count <= '0;
                        win_ones  <= '0;
                    end else begin
                        win_count <= win_count + 7'h01;
                        win_ones  <= win_ones + {6'h00, line_bit_i};
                    end
                end
                default: los_state <= LOS_IDLE;
            endcase
        end
    end

    // Per-second E-bit tally; a second is spoiled by remote alarm or sync loss
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ebit_count  <= '0;
            sec_spoiled <= 1'b0;
            bad_secs    <= '0;
            remote_multiframe_failure       <= 1'b0;
        end else if (second_tick_i) begin
            ebit_count  <= {9'h000, ebit_error_i};  // Tick-cycle events open the new second
            sec_spoiled <= rai_seen || frame_sync_lost_i;
            if (ebit_count > EBIT_LIMIT && !sec_spoiled) begin
                if (bad_secs != REMOTE_MULTIFRAME_FAILURE_SECS)
                    bad_secs <= bad_secs + 3'h1;
                remote_multiframe_failure <= bad_secs >= REMOTE_MULTIFRAME_FAILURE_SECS - 3'h1;
            end else begin
                bad_secs <= '0;
                remote_multiframe_failure    <= 1'b0;
            end
        end else begin
            if (ebit_error_i && ebit_count != 10'h3ff)
                ebit_count <= ebit_count + 10'h001;
            if (rai_seen || frame_sync_lost_i)
                sec_spoiled <= 1'b1;
        end
    end

    // Sa6 repetition tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_nibble <= 4'h0;
            nibble_seen <= 1'b0;
            same_run    <= '0;
        end else if (frame_ev_i.sa6_valid) begin
            last_nibble <= frame_ev_i.sa6_nibble;
            nibble_seen <= 1'b1;
            if (nibble_seen && frame_ev_i.sa6_nibble == last_nibble)
                same_run <= (same_run == SA6_REPEAT) ? same_run : same_run + 3'h1;
            else
                same_run <= '0;
        end
    end
    logic sa6_eighth;
    logic sa6_change;
    assign sa6_eighth = frame_ev_i.sa6_valid && nibble_seen
                        && frame_ev_i.sa6_nibble == last_nibble
                        && same_run == SA6_REPEAT - 3'h1;
    assign sa6_change = frame_ev_i.sa6_valid && nibble_seen
                        && frame_ev_i.sa6_nibble != last_nibble;

    // Spare-bit report; read clears, but a same-cycle event survives it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spare_word <= RST_BYTE;
        end else begin
            if (spare_clear)
                spare_word <= RST_BYTE;
            if (sa6_eighth) begin
                spare_word[7]   <= frame_ev_i.sa5_bit;
                spare_word[6:3] <= frame_ev_i.sa6_nibble;
                spare_word[1]   <= 1'b1;
            end
            if (sa6_change)
                spare_word[0] <= 1'b1;
            spare_word[2] <= 1'b0;
        end
    end

    default clocking e1rs_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)  // bus
        else $error("ack held for more than one cycle");
    a_ident_fixed: assert property (
        bus_req && !wb_req_i.we && !wb_ack_o && bus_idx == IDX_IDENT
        |=> wb_dat_o[7:0] == IDENT_VALUE)
        else $error("identification word wrong");
    a_phase_capture: assert property (
        receive_frame_pulse_i && !backplane_frame_pulse_i
        |=> phase_count == $past(phase_run))
        else $error("phase count not captured");
    a_fifo_empty_flag: assert property (
        jitter_fifo_level_i == '0 |=> jitter_word[5] && !jitter_word[4])
        else $error("empty flag wrong");
    a_fifo_half_flag: assert property (
        jitter_fifo_level_i >= LVL_HALF |=> jitter_word[3] && jitter_word[4])
        else $error("half flag wrong");
    a_los_zero_run: assert property (
        los_state == LOS_IDLE && bit_strobe_i && !line_bit_i
        && zero_run == LOS_ZERO_RUN - 7'h01 |=> los_state == LOS_LOST)
        else $error("loss of signal not entered");
    a_los_stay_idle: assert property (
        los_state == LOS_IDLE && bit_strobe_i && line_bit_i
        |=> los_state == LOS_IDLE && zero_run == '0)
        else $error("pulse did not reset zero run");
    a_spare_set_wins: assert property (
        spare_clear && sa6_change |=> spare_word[0])
        else $error("event lost to clearing read");
    a_spare_read_clear: assert property (
        spare_clear && !sa6_change && !sa6_eighth |=> spare_word == RST_BYTE)
        else $error("report not cleared by read");
    a_ais_select: assert property (
        ais_sel && ais_criterion_b_i ##1 ais_sel |-> ais_seen)
        else $error("AIS criterion select ignored");
    a_rai_refresh: assert property (
        frame_ev_i.nfas_strobe |=> rai_seen == $past(frame_ev_i.remote_a_bit))
        else $error("remote alarm not refreshed");
endmodule // e1rs_status_regs

`default_nettype wire
